/* File: rtl/mce_bank.sv */
`timescale 1ns/100ps
`include "mce_defines.svh"

module mce_bank
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control side
    mce_bank_if.bank bif
);

    mce_pkg::mce_bank_state_t r;
    mce_pkg::mce_bank_state_t next_r;

    // software writes first, so a log in the same cycle wins
    always_comb
    begin
        next_r = r;
        if (bif.wrStatus)
        begin
            next_r.status = bif.wdata;
        end
        if (bif.wrLoc)
        begin
            next_r.location = bif.wdata[31:0];
        end
        if (bif.wrExtra)
        begin
            next_r.extra = bif.wdata[31:0];
        end
        if (bif.logEn)
        begin
            if (next_r.status[`MCE_ST_VALID])
            begin
                next_r.status[`MCE_ST_LOST] = 1'b1;      // [RL5] [RL18]
            end
            else
            begin
                next_r = bif.newRec;                      // [RL13]
            end
        end
    end

    // state register; empty bank reads code zero
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;                                      // [RL19]
        end
        else
        begin
            r <= next_r;
        end
    end

    assign bif.state = r;

endmodule : mce_bank

/* File: rtl/mce_bank_if.sv */
`timescale 1ns/100ps

interface mce_bank_if;
    logic                     logEn;
    mce_pkg::mce_bank_state_t newRec;
    logic                     wrStatus;
    logic                     wrLoc;
    logic                     wrExtra;
    logic [63:0]              wdata;
    mce_pkg::mce_bank_state_t state;

    modport bank (input logEn, newRec, wrStatus, wrLoc, wrExtra, wdata,
                  output state);
    modport ctrl (output logEn, newRec, wrStatus, wrLoc, wrExtra, wdata,
                  input state);
endinterface : mce_bank_if

/* File: rtl/mce_check_unit.sv */
`timescale 1ns/100ps
`include "mce_defines.svh"

// Summary of operation
// RL1 - an uncorrected error raises the machine-check trap on vector 18
// RL2 - capability register reports how many banks exist
// RL3 - bank zero starts at register address 400H, others follow
// RL4 - status valid flag marks that the bank holds an error
// RL5 - second error before clearing sets the lost-error flag
// RL6 - context-corrupt flag marks state damage, not restartable
// RL7 - uncorrected flag tells hardware could not fix the error
// RL8 - restart-pointer flag set only when resuming is reliable
// RL9 - pointer-tied flag set when pushed address relates to error
// RL10 - raising the trap sets check-in-progress
// RL11 - a trap while check-in-progress is set enters shutdown
// RL12 - corrected errors are logged without any trap
// RL13 - a cleared bank takes the next error and becomes valid
// RL14 - software writes zeros to status then re-reads to confirm
// RL15 - location and extra flags tell which registers are meaningful
// RL16 - legacy mode with trap enabled keeps kind and location apart
// RL17 - handler clears check-in-progress before returning
// RL18 - a valid bank keeps its record and only sets lost-error
// RL19 - error code reads all zeros when no error was reported
module mce_check_unit
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // register port
    input  wire logic [15:0] regAddr,
    input  wire logic [63:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [63:0] regRdata,
    // error report from the core
    input  wire logic        errValid,
    input  wire logic [1:0]  errBank,
    input  wire logic [15:0] errCode,
    input  wire logic        errUncorr,
    input  wire logic        errCorrupt,
    input  wire logic        errLocValid,
    input  wire logic [31:0] errLoc,
    input  wire logic        errExtraValid,
    input  wire logic [31:0] errExtra,
    input  wire logic        errRestartOk,
    input  wire logic        errPointerTied,
    // trap and status outputs
    output logic             trapReq,
    output logic      [7:0]  trapVector,
    output logic             shutdown,
    output logic             irq
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************

    // true when the address hits a given offset of any bank
    function automatic logic isBankReg
    (
        input logic [15:0] addr,
        input logic [1:0]  ofs
    );
        isBankReg = (addr[15:4] == `MCE_BANK_PAGE) && (addr[1:0] == ofs);
    endfunction : isBankReg

    // bank index carried by a bank register address
    function automatic logic [`MCE_BANK_IDX_W-1:0] bankOf
    (
        input logic [15:0] addr
    );
        bankOf = addr[3:2];
    endfunction : bankOf

    // status writes keep only the defined fields, so reserved bits
    // read zero whatever software writes into them
    function automatic logic [63:0] statusFields
    (
        input logic [63:0] word
    );
        statusFields = '0;
        statusFields[`MCE_ST_VALID] = word[`MCE_ST_VALID];
        statusFields[`MCE_ST_LOST] = word[`MCE_ST_LOST];
        statusFields[`MCE_ST_UNCORR] = word[`MCE_ST_UNCORR];
        statusFields[`MCE_ST_EXTRA_V] = word[`MCE_ST_EXTRA_V];
        statusFields[`MCE_ST_LOC_V] = word[`MCE_ST_LOC_V];
        statusFields[`MCE_ST_CORRUPT] = word[`MCE_ST_CORRUPT];
        statusFields[`MCE_CODE_W-1:0] = word[`MCE_CODE_W-1:0];
    endfunction : statusFields

    // ****************************************************************
    // state
    // ****************************************************************
    mce_pkg::mce_state_t      r;
    mce_pkg::mce_state_t      next_r;
    mce_pkg::mce_bank_state_t bankState [`MCE_NUM_BANKS];
    mce_pkg::mce_bank_state_t newRec;
    logic                     bankValid;

    mce_bank_if bankIf [`MCE_NUM_BANKS] ();

    // ****************************************************************
    // banks
    // ****************************************************************

    // record formed from the incoming error
    always_comb
    begin
        newRec = '0;
        newRec.status[`MCE_ST_VALID] = 1'b1;                  // [RL4]
        newRec.status[`MCE_ST_UNCORR] = errUncorr;            // [RL7]
        newRec.status[`MCE_ST_CORRUPT] = errCorrupt;          // [RL6]
        newRec.status[`MCE_ST_LOC_V] = errLocValid;           // [RL15]
        newRec.status[`MCE_ST_EXTRA_V] = errExtraValid;       // [RL15]
        newRec.status[`MCE_CODE_W-1:0] = errCode;
        newRec.location = errLocValid ? errLoc : '0;
        newRec.extra = errExtraValid ? errExtra : '0;
    end

    // ****************************************************************
    // bank instances
    // ****************************************************************

    // one bank per index, writes decoded by address
    for (genvar g = 0; g < `MCE_NUM_BANKS; g++)
    begin : genBank
        logic bankSel;

        assign bankSel = regWr &&
            (bankOf(regAddr) == (`MCE_BANK_IDX_W)'(g));
        assign bankIf[g].logEn = errValid &&
            (errBank == (`MCE_BANK_IDX_W)'(g));
        assign bankIf[g].newRec = newRec;
        assign bankIf[g].wdata = isBankReg(regAddr, `MCE_OFS_STATUS) ?
            statusFields(regWdata) : regWdata;
        assign bankIf[g].wrStatus = bankSel &&
            isBankReg(regAddr, `MCE_OFS_STATUS);               // [RL3]
        assign bankIf[g].wrLoc = bankSel &&
            isBankReg(regAddr, `MCE_OFS_LOC);
        assign bankIf[g].wrExtra = bankSel &&
            isBankReg(regAddr, `MCE_OFS_EXTRA);
        assign bankState[g] = bankIf[g].state;

        mce_bank uBank
        (
            .clock (clock),
            .rstn  (rstn),
            .bif   (bankIf[g])
        );
    end

    // ****************************************************************
    // lost detection
    // ****************************************************************

    // a record held in the target bank, seen through a same-cycle
    // status write just as the bank itself sees it
    always_comb
    begin
        bankValid = bankState[errBank].status[`MCE_ST_VALID];
        // a software clear in this cycle frees the bank for the record
        if (regWr && isBankReg(regAddr, `MCE_OFS_STATUS) &&
            (bankOf(regAddr) == errBank))
        begin
            bankValid = regWdata[`MCE_ST_VALID];          // [RL18]
        end
    end

    // ****************************************************************
    // control logic
    // ****************************************************************

    // next state of the checking logic
    always_comb
    begin
        next_r = r;
        next_r.trap = 1'b0;
        next_r.rdata = '0;

        // software writes, done before hardware events so sets win
        if (regWr)
        begin
            case (regAddr)
                `MCE_ADDR_GSTAT:
                begin
                    next_r.gStatus = regWdata[2:0];           // [RL17]
                end
                `MCE_ADDR_CTRL:
                begin
                    next_r.ctrl = regWdata[1:0];
                end
                `MCE_ADDR_INT_STAT:
                begin
                    next_r.intStatus = r.intStatus & ~regWdata[3:0];
                end
                `MCE_ADDR_INT_MASK:
                begin
                    next_r.intMask = regWdata[3:0];
                end
                default:
                begin
                    next_r.ctrl = next_r.ctrl;
                end
            endcase
        end

        // hardware error events
        if (errValid)
        begin
            if (bankValid)
            begin
                next_r.intStatus[`MCE_INT_LOST] = 1'b1;       // [RL5]
            end
            if (!errUncorr)
            begin
                next_r.intStatus[`MCE_INT_CORR] = 1'b1;       // [RL12]
            end
            else
            begin
                next_r.intStatus[`MCE_INT_UNCORR] = 1'b1;
                if (r.ctrl[`MCE_CTRL_ENABLE] && r.mode == mce_pkg::MCE_RUN)
                begin
                    if (r.gStatus[`MCE_G_INPROG])
                    begin
                        next_r.mode = mce_pkg::MCE_HALTED;    // [RL11]
                        next_r.shutdown = 1'b1;               // [RL11]
                        next_r.intStatus[`MCE_INT_SHUT] = 1'b1;
                    end
                    else
                    begin
                        next_r.trap = 1'b1;                   // [RL1]
                        next_r.trapVector = `MCE_TRAP_VECTOR; // [RL1]
                        next_r.gStatus[`MCE_G_INPROG] = 1'b1; // [RL10]
                        next_r.gStatus[`MCE_G_RESTART] =
                            errRestartOk && !errCorrupt;      // [RL8]
                        next_r.gStatus[`MCE_G_TIED] =
                            errPointerTied;                   // [RL9]
                    end
                    if (r.ctrl[`MCE_CTRL_LEGACY])
                    begin
                        next_r.legacyKind = errCode;          // [RL16]
                        next_r.legacyLoc = errLoc;            // [RL16]
                    end
                end
            end
        end

        // register reads, answered in the following cycle
        if (regRd)
        begin
            if (regAddr[15:4] == `MCE_BANK_PAGE)
            begin
                case (regAddr[1:0])
                    `MCE_OFS_STATUS:
                    begin
                        next_r.rdata = bankState[bankOf(regAddr)].status;
                    end
                    `MCE_OFS_LOC:
                    begin
                        next_r.rdata[31:0] =
                            bankState[bankOf(regAddr)].location;
                    end
                    `MCE_OFS_EXTRA:
                    begin
                        next_r.rdata[31:0] =
                            bankState[bankOf(regAddr)].extra;
                    end
                    default:
                    begin
                        next_r.rdata = '0;
                    end
                endcase
            end
            else
            begin
                case (regAddr)
                    `MCE_ADDR_CAP:
                    begin
                        next_r.rdata[`MCE_CAP_COUNT_W-1:0] =
                            (`MCE_CAP_COUNT_W)'(`MCE_NUM_BANKS); // [RL2]
                    end
                    `MCE_ADDR_GSTAT:
                    begin
                        next_r.rdata[2:0] = r.gStatus;
                    end
                    `MCE_ADDR_CTRL:
                    begin
                        next_r.rdata[1:0] = r.ctrl;
                    end
                    `MCE_ADDR_INT_STAT:
                    begin
                        next_r.rdata[3:0] = r.intStatus;
                    end
                    `MCE_ADDR_INT_MASK:
                    begin
                        next_r.rdata[3:0] = r.intMask;
                    end
                    `MCE_ADDR_LEG_KIND:
                    begin
                        next_r.rdata[15:0] = r.legacyKind;
                    end
                    `MCE_ADDR_LEG_LOC:
                    begin
                        next_r.rdata[31:0] = r.legacyLoc;
                    end
                    default:
                    begin
                        next_r.rdata = '0;
                    end
                endcase
            end
        end

        // level interrupt from unmasked sticky bits
        next_r.irq = |(next_r.intStatus & next_r.intMask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // all control state in one register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
            r.mode <= mce_pkg::MCE_RUN;
            r.trapVector <= `MCE_TRAP_VECTOR;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from the register
    assign regRdata = r.rdata;
    assign trapReq = r.trap;
    assign trapVector = r.trapVector;
    assign shutdown = r.shutdown;
    assign irq = r.irq;

endmodule : mce_check_unit

/* File: rtl/mce_defines.svh */
`ifndef MCE_DEFINES_SVH
`define MCE_DEFINES_SVH

// ****************************************************************
// bank layout
// ****************************************************************
`define MCE_NUM_BANKS     4
`define MCE_BANK_IDX_W    2
`define MCE_BANK_PAGE     12'h040
`define MCE_OFS_STATUS    2'h0
`define MCE_OFS_LOC       2'h1
`define MCE_OFS_EXTRA     2'h2

// ****************************************************************
// global register addresses
// ****************************************************************
`define MCE_ADDR_LEG_LOC  16'h0000
`define MCE_ADDR_LEG_KIND 16'h0001
`define MCE_ADDR_CAP      16'h0010
`define MCE_ADDR_GSTAT    16'h0011
`define MCE_ADDR_CTRL     16'h0020
`define MCE_ADDR_INT_STAT 16'h0021
`define MCE_ADDR_INT_MASK 16'h0022

// ****************************************************************
// bank status fields
// ****************************************************************
`define MCE_ST_VALID      63
`define MCE_ST_LOST       62
`define MCE_ST_UNCORR     61
`define MCE_ST_EXTRA_V    59
`define MCE_ST_LOC_V      58
`define MCE_ST_CORRUPT    57
`define MCE_CODE_W        16
`define MCE_NO_ERROR_CODE 16'h0000

// ****************************************************************
// global status, control and interrupt fields
// ****************************************************************
`define MCE_G_RESTART     0
`define MCE_G_TIED        1
`define MCE_G_INPROG      2
`define MCE_CTRL_ENABLE   0
`define MCE_CTRL_LEGACY   1
`define MCE_INT_CORR      0
`define MCE_INT_UNCORR    1
`define MCE_INT_LOST      2
`define MCE_INT_SHUT      3
`define MCE_CAP_COUNT_W   8
`define MCE_TRAP_VECTOR   8'h12

`endif

/* File: rtl/mce_pkg.sv */
`include "mce_defines.svh"

package mce_pkg;

    // run state of the checking logic
    typedef enum logic {MCE_RUN, MCE_HALTED} mce_mode_t;

    // one error-reporting bank
    typedef struct packed
    {
        logic [63:0] status;
        logic [31:0] location;
        logic [31:0] extra;
    } mce_bank_state_t;

    // all state of the top module
    typedef struct packed
    {
        mce_mode_t   mode;
        logic [2:0]  gStatus;
        logic [1:0]  ctrl;
        logic [3:0]  intStatus;
        logic [3:0]  intMask;
        logic [15:0] legacyKind;
        logic [31:0] legacyLoc;
        logic [63:0] rdata;
        logic        trap;
        logic [7:0]  trapVector;
        logic        irq;
        logic        shutdown;
    } mce_state_t;

endpackage : mce_pkg

/* File: sim/mce_check_unit_asserts.sv */
`timescale 1ns/100ps

// ****************************************************************
// trap, shutdown and bank count checks at the top ports
// ****************************************************************
module mce_check_unit_asserts
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic        regRd,
    input wire logic [63:0] regRdata,
    // error report
    input wire logic        errValid,
    input wire logic        errUncorr,
    // outputs under watch
    input wire logic        trapReq,
    input wire logic [7:0]  trapVector,
    input wire logic        shutdown
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // trap identity and its cause
    a_vector_fixed: assert property (trapVector == 8'h12)
        else $error("trap vector is not 18");
    a_trap_cause: assert property (
        trapReq |-> $past(errValid && errUncorr))
        else $error("trap without an uncorrected error");
    a_corr_no_trap: assert property (
        errValid && !errUncorr |=> !trapReq)
        else $error("corrected error raised a trap");
    a_trap_single: assert property (trapReq |=> !trapReq)
        else $error("trap pulse longer than one cycle");
    // shutdown on recursion
    a_shut_sticky: assert property (shutdown |=> shutdown)
        else $error("shutdown dropped before reset");
    a_no_trap_shut: assert property (shutdown |-> !trapReq)
        else $error("trap raised in shutdown");
    a_shut_cause: assert property (
        $rose(shutdown) |-> $past(errValid && errUncorr))
        else $error("shutdown without an uncorrected error");
    // bank count readout
    a_cap_count: assert property (
        regRd && regAddr == 16'h0010 |=> regRdata == 64'h4)
        else $error("bank count is not 4");

    // main scenarios
    c_trap: cover property (trapReq);
    c_shut: cover property ($rose(shutdown));
    c_corr: cover property (errValid && !errUncorr);
endmodule : mce_check_unit_asserts

bind mce_check_unit mce_check_unit_asserts chk_u
(
    .clock(clock), .rstn(rstn), .regAddr(regAddr), .regRd(regRd),
    .regRdata(regRdata), .errValid(errValid), .errUncorr(errUncorr),
    .trapReq(trapReq), .trapVector(trapVector), .shutdown(shutdown)
);

/* File: sim/mce_check_unit_tb.sv */
`timescale 1ns/100ps

module mce_check_unit_tb;
    logic clock = 0, rstn = 0, regWr = 0, regRd = 0, errValid = 0;
    logic [15:0] regAddr = 0, errCode = 0;
    logic [63:0] regWdata = 0, regRdata;
    logic [1:0]  errBank = 0;
    logic [5:0]  fl = 0;
    logic [31:0] errLoc = 0, errExtra = 0;
    logic trapReq, shutdown, irq;
    logic [7:0] trapVector;
    int mismatches = 0, n_checks = 0, cyc = 0, i;
    // ****************************************************************
    // behavioural model state
    // ****************************************************************
    logic [63:0] st[4] = '{default: 0};
    logic [31:0] lc[4] = '{default: 0}, ex[4] = '{default: 0};
    logic [2:0] gs = 0;
    logic [1:0] ct = 0;
    logic [3:0] is = 0, im = 0;
    logic [15:0] lk = 0;
    logic [31:0] ll = 0;
    logic sh = 0, tr;

    mce_check_unit dut_u
    (
        .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .errValid(errValid), .errBank(errBank), .errCode(errCode),
        .errUncorr(fl[5]), .errCorrupt(fl[4]), .errLocValid(fl[3]),
        .errLoc(errLoc), .errExtraValid(fl[2]), .errExtra(errExtra),
        .errRestartOk(fl[1]), .errPointerTied(fl[0]), .trapReq(trapReq),
        .trapVector(trapVector), .shutdown(shutdown), .irq(irq)
    );

    // clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            test_done();
        end
    end

    // ****************************************************************
    // compare, bus and error tasks
    // ****************************************************************
    task automatic cmp(input string w, input logic [63:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : cmp

    function automatic logic [63:0] mrd(input logic [15:0] a);
        if (a[15:4] == 12'h040)
            return a[1:0] == 0 ? st[a[3:2]] : a[1:0] == 1 ? {32'h0, lc[a[3:2]]}
                 : a[1:0] == 2 ? {32'h0, ex[a[3:2]]} : 64'h0;
        case (a)
            16'h0000: return {32'h0, ll};
            16'h0001: return {48'h0, lk};
            16'h0010: return 64'h4;
            16'h0011: return {61'h0, gs};
            16'h0020: return {62'h0, ct};
            16'h0021: return {60'h0, is};
            16'h0022: return {60'h0, im};
            default:  return 64'h0;
        endcase
    endfunction : mrd

    task automatic rd(input logic [15:0] a);
        logic [63:0] e;
        e = mrd(a);
        @(posedge clock);
        regRd <= 1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 0;
        #1 cmp("regRdata", e, regRdata);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        @(posedge clock);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        if (a[15:4] == 12'h040 && a[1:0] == 0)
            st[a[3:2]] = d & 64'hEE00_0000_0000_FFFF;
        if (a == 16'h0011) gs = d[2:0];
        if (a == 16'h0020) ct = d[1:0];
        if (a == 16'h0021) is &= ~d[3:0];
        if (a == 16'h0022) im = d[3:0];
        @(posedge clock);
        regWr <= 0;
    endtask : wr

    task automatic err(input logic [1:0] b, input logic [5:0] f);
        logic [15:0] c;
        logic [31:0] l, x;
        c = 16'($urandom);
        l = $urandom;
        x = $urandom;
        @(posedge clock);
        {errValid, errBank, errCode, fl} <= {1'b1, b, c, f};
        {errLoc, errExtra} <= {l, x};
        tr = 0;
        if (st[b][63])
        begin
            st[b][62] = 1;
            is[2] = 1;
        end
        else
        begin
            st[b] = {2'b10, f[5], 1'b0, f[2], f[3], f[4], 41'h0, c};
            lc[b] = f[3] ? l : 32'h0;
            ex[b] = f[2] ? x : 32'h0;
        end
        is[f[5]] = 1;
        if (f[5] && ct[0] && !sh)
        begin
            if (ct[1])
                {lk, ll} = {c, l};
            if (gs[2])
                {sh, is[3]} = 2'b11;
            else
                {tr, gs} = {2'b11, f[0], f[1] & !f[4]};
        end
        @(posedge clock);
        errValid <= 0;
        #1 cmp("trapReq", tr, trapReq);
        cmp("shutdown", sh, shutdown);
    endtask : err

    task automatic chk_irq();
        repeat (2) @(posedge clock);
        #1 cmp("irq", |(is & im), irq);
    endtask : chk_irq

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(92));
        repeat (6) @(posedge clock);
        rstn <= 1;
        for (i = 0; i < 16; i++) rd(16'h0400 + i[15:0]);
        rd(16'h0010);
        rd(16'h0030);
        cmp("trapVector", 64'h12, {56'h0, trapVector});
        $display("test reset done");
        wr(16'h0020, 64'h1);
        err(2'd1, 6'b001100);
        for (i = 4; i < 7; i++) rd(i[15:0] + 16'h0400);
        err(2'd1, 6'b000000);
        rd(16'h0404);
        wr(16'h0404, {64{1'b1}});
        rd(16'h0404);
        wr(16'h0404, 64'h0);
        rd(16'h0404);
        err(2'd1, 6'b000100);
        rd(16'h0404);
        $display("test bank log done");
        chk_irq();
        wr(16'h0022, 64'h1);
        chk_irq();
        wr(16'h0021, 64'h5);
        chk_irq();
        rd(16'h0021);
        $display("test interrupt done");
        wr(16'h0020, 64'h3);
        err(2'd0, 6'b110011);
        for (i = 0; i < 2; i++) rd(i[15:0]);
        rd(16'h0400);
        rd(16'h0011);
        wr(16'h0011, 64'h0);
        err(2'd2, 6'b100010);
        rd(16'h0011);
        $display("test trap done");
        err(2'd3, 6'b100000);
        err(2'd3, 6'b100000);
        rd(16'h0021);
        $display("test shutdown done");
        test_done();
    end
endmodule : mce_check_unit_tb
